/* File: hw/fcnt_top.sv */
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - pulses and quadrature edges up to 50 kHz are counted without loss
// - with up_down_select low, modes 1 to 6 count upward from preload toward the target
// - count is 16-bit signed; +32767 plus one wraps to -32768
// - up_down_select high decrements in modes 3 to 6; -32768 minus one gives +32767
// - reaching the target in either direction sets the sticky target flag
// - only a reload, by set or by a change of direction, clears the target flag
// - counting only while enabled, by the enable input, plus a pin gate in mode 2
// - a set request from pin or set input copies the preload word in
// - set and enable both held reload each program cycle, counting between
// - present count is always readable as the actual value
// - fault flag is high whenever the fault code word holds an error
// - low byte of mode word picks mode 00..07, high byte is 00
// - a new mode word takes effect only at an initialization
// - mode 0 disables counting and frees both pins and the output
// - mode 1 counts the first pin, drives the output, both gated by enable
// - mode 2 adds a gate taken from the second pin
// - mode 4 second counter counts falling edges
// - modes 5 and 6 preload on rising or falling edge of the second pin
// - mode 7 counts up or down from the phase of two tracks
// - mode 2 counts and drives output only with second pin and enable high
// - a change of direction reloads the preload; outside mode 7 it then counts the new way
// - quadrature counts once per signal cycle, no multiplication, no index
module fcnt_top (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        count_input_pin_i,
  input  wire logic        second_input_pin_i,
  input  wire logic        program_cycle_end_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  output logic             target_reached_pin_o,
  output logic             pins_released_o,
  output logic             fault_flag_o
);
  import fcnt_pkg::*;

  fcnt_cnt_if ch0 ();
  fcnt_cnt_if ch1 ();

  // software registers
  logic [15:0]   mode_config_word_r;
  fcnt_mode_type mode_r;
  logic [7:0]    fault_code_r;
  logic [6:0]    ctrl_r;
  logic [15:0]   pre0_r;
  logic [15:0]   tgt0_r;
  logic [15:0]   pre1_r;
  logic [15:0]   tgt1_r;
  logic [15:0]   rdata_r;
  logic          out_pin_r;
  logic          released_r;
  logic          fault_r;
  logic          ud0_prev_r;
  logic          ud1_prev_r;
  logic          set0_pend_r;
  logic          set1_pend_r;

  // synchronised fast pins
  wire a_lvl;
  wire a_rise;
  wire a_fall;
  wire b_lvl;
  wire b_rise;
  wire b_fall;

  fcnt_sync u_sync_a (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   (count_input_pin_i),
    .level_o (a_lvl),
    .rise_o  (a_rise),
    .fall_o  (a_fall)
  );

  fcnt_sync u_sync_b (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   (second_input_pin_i),
    .level_o (b_lvl),
    .rise_o  (b_rise),
    .fall_o  (b_fall)
  );

  // mode decode
  wire m_none = (mode_r == FCNT_M_NONE);
  wire m_up   = (mode_r == FCNT_M_UP);
  wire m_gate = (mode_r == FCNT_M_GATE);
  wire m_dual = (mode_r == FCNT_M_DUAL) || (mode_r == FCNT_M_DINV);
  wire m_dinv = (mode_r == FCNT_M_DINV);
  wire m_esr  = (mode_r == FCNT_M_ESR);
  wire m_esf  = (mode_r == FCNT_M_ESF);
  wire m_edge = m_esr || m_esf;
  wire m_quad = (mode_r == FCNT_M_QUAD);
  wire ud_ok  = m_dual || m_edge || m_quad; // modes that may count down

  wire en0  = ctrl_r[FCNT_CTRL_EN0];
  wire set0 = ctrl_r[FCNT_CTRL_SET0];
  wire ud0  = ctrl_r[FCNT_CTRL_UD0] & ud_ok;
  wire en1  = ctrl_r[FCNT_CTRL_EN1];
  wire set1 = ctrl_r[FCNT_CTRL_SET1];
  wire ud1  = ctrl_r[FCNT_CTRL_UD1] & ud_ok;

  // enables: block enable always, plus pin gate in mode 2
  wire gate0 = en0 & ~m_none & (~m_gate | b_lvl);

  // quadrature: one count per full cycle, on A rising; B level gives direction
  // A rising with B low means A leads (up); with B high B leads (down)
  wire q_step = a_rise;
  wire q_up   = q_step & ~b_lvl;
  wire q_dn   = q_step &  b_lvl;

  // pulse for counter 0, one per rising edge of first pin
  wire pulse0 = m_quad ? 1'b0 : a_rise;
  // counter 1 counts second pin, falling edges in mode 4
  wire pulse1 = m_dinv ? b_fall : b_rise;

  // direction change forces reload
  wire ud0_chg = (ud0 != ud0_prev_r);
  wire ud1_chg = m_dual & (ud1 != ud1_prev_r);

  // edge set from second pin in modes 5/6
  wire pin_set = (m_esr & b_rise) | (m_esf & b_fall);

  // set with enable is applied at every program cycle end
  wire cyc_set0 = set0 & program_cycle_end_i;
  wire cyc_set1 = set1 & program_cycle_end_i & m_dual;

  wire load0 = ~m_none & (set0_pend_r | cyc_set0 | pin_set | ud0_chg);
  wire load1 = m_dual & (set1_pend_r | cyc_set1 | ud1_chg);

  // counter 0 steps
  wire st0 = gate0 & (m_quad ? 1'b1 : pulse0);
  assign ch0.step_up = ~load0 & (m_quad ? (gate0 & q_up) : (st0 & ~ud0));
  assign ch0.step_dn = ~load0 & (m_quad ? (gate0 & q_dn) : (st0 &  ud0));
  assign ch0.load    = load0;
  assign ch0.preload = pre0_r;
  assign ch0.target  = tgt0_r;

  // counter 1 exists only in dual modes
  wire st1 = m_dual & en1 & pulse1;
  assign ch1.step_up = ~load1 & st1 & ~ud1;
  assign ch1.step_dn = ~load1 & st1 &  ud1;
  assign ch1.load    = load1;
  assign ch1.preload = pre1_r;
  assign ch1.target  = tgt1_r;

  fcnt_chan u_ch0 (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .c       (ch0.cnt)
  );

  fcnt_chan u_ch1 (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .c       (ch1.cnt)
  );

  // register decode
  wire wr_mode = wr_i && addr_i == FCNT_ADDR_MODE;
  wire wr_ctrl = wr_i && addr_i == FCNT_ADDR_CTRL;
  wire wr_init = wr_i && addr_i == FCNT_ADDR_INIT;
  wire [7:0] mode_lo = mode_config_word_r[7:0];
  wire [7:0] mode_hi = mode_config_word_r[15:8];
  // unknown or malformed mode word falls back to no counter
  wire       mode_bad = (mode_lo > FCNT_M_QUAD) || (mode_hi != 8'h00);
  wire [7:0] fault_nxt = (mode_hi != 8'h00) ? FCNT_FAULT_HIGH :
                         (mode_lo > FCNT_M_QUAD) ? FCNT_FAULT_MODE : FCNT_FAULT_NONE;

  // output terminal only in modes 1 and 2, gated by enable
  wire out_nxt = (m_up & en0 & ch0.reached) | (m_gate & gate0 & ch0.reached);

  // read mux; actual values always readable
  logic [15:0] rd_mux;
  always_comb begin
    case (addr_i)
      FCNT_ADDR_MODE:    rd_mux = mode_config_word_r;
      FCNT_ADDR_CTRL:    rd_mux = {9'h000, ctrl_r};
      FCNT_ADDR_PRELOAD: rd_mux = pre0_r;
      FCNT_ADDR_TARGET:  rd_mux = tgt0_r;
      FCNT_ADDR_PRE1:    rd_mux = pre1_r;
      FCNT_ADDR_TGT1:    rd_mux = tgt1_r;
      FCNT_ADDR_COUNT0:  rd_mux = ch0.count;
      FCNT_ADDR_COUNT1:  rd_mux = ch1.count;
      FCNT_ADDR_STATUS:  rd_mux = {fault_code_r, mode_r[3:0], 1'b0, fault_r,
                                   ch1.reached, ch0.reached};
      default:           rd_mux = FCNT_ZERO16;
    endcase
  end

  // software writes and mode latch; mode moves only on init
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_config_word_r <= FCNT_MODE_RESET;
      mode_r             <= FCNT_M_NONE;
      fault_code_r       <= FCNT_FAULT_NONE;
      ctrl_r             <= 7'h00;
      pre0_r             <= FCNT_ZERO16;
      tgt0_r             <= FCNT_ZERO16;
      pre1_r             <= FCNT_ZERO16;
      tgt1_r             <= FCNT_ZERO16;
    end else begin
      if (wr_mode)
        mode_config_word_r <= wdata_i;
      if (wr_ctrl)
        ctrl_r <= wdata_i[6:0];
      if (wr_i && addr_i == FCNT_ADDR_PRELOAD)
        pre0_r <= wdata_i;
      if (wr_i && addr_i == FCNT_ADDR_TARGET)
        tgt0_r <= wdata_i;
      if (wr_i && addr_i == FCNT_ADDR_PRE1)
        pre1_r <= wdata_i;
      if (wr_i && addr_i == FCNT_ADDR_TGT1)
        tgt1_r <= wdata_i;
      if (wr_init) begin
        mode_r       <= mode_bad ? FCNT_M_NONE : fcnt_mode_type'(mode_lo);
        fault_code_r <= fault_nxt;
      end
    end
  end

  // set edge from software and direction history
  // a write that raises set loads once at once; holding it reloads per cycle end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      set0_pend_r <= 1'b0;
      set1_pend_r <= 1'b0;
      ud0_prev_r  <= 1'b0;
      ud1_prev_r  <= 1'b0;
    end else begin
      set0_pend_r <= wr_ctrl & wdata_i[FCNT_CTRL_SET0] & ~set0;
      set1_pend_r <= wr_ctrl & wdata_i[FCNT_CTRL_SET1] & ~set1;
      ud0_prev_r  <= ud0;
      ud1_prev_r  <= ud1;
    end
  end

  // registered outputs
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r    <= FCNT_ZERO16;
      out_pin_r  <= 1'b0;
      released_r <= 1'b1;
      fault_r    <= 1'b0;
    end else begin
      rdata_r    <= rd_i ? rd_mux : FCNT_ZERO16;
      out_pin_r  <= out_nxt;
      released_r <= m_none;
      fault_r    <= (fault_code_r != FCNT_FAULT_NONE);
    end
  end

  assign rdata_o              = rdata_r;
  assign target_reached_pin_o = out_pin_r;
  assign pins_released_o      = released_r;
  assign fault_flag_o         = fault_r;
endmodule

/* File: hw/fcnt_pkg.sv */
package fcnt_pkg;
  // register map of the plain register port
  localparam logic [3:0] FCNT_ADDR_MODE    = 4'h0; // mode_config_word
  localparam logic [3:0] FCNT_ADDR_CTRL    = 4'h1; // enable/set/updown, counter 0 and 1
  localparam logic [3:0] FCNT_ADDR_PRELOAD = 4'h2; // preload word, counter 0
  localparam logic [3:0] FCNT_ADDR_TARGET  = 4'h3; // target word, counter 0
  localparam logic [3:0] FCNT_ADDR_PRE1    = 4'h4; // preload word, counter 1
  localparam logic [3:0] FCNT_ADDR_TGT1    = 4'h5; // target word, counter 1
  localparam logic [3:0] FCNT_ADDR_COUNT0  = 4'h6; // actual value, counter 0
  localparam logic [3:0] FCNT_ADDR_COUNT1  = 4'h7; // actual value, counter 1
  localparam logic [3:0] FCNT_ADDR_STATUS  = 4'h8; // flags and fault code
  localparam logic [3:0] FCNT_ADDR_INIT    = 4'h9; // write: initialization (warm start)

  // control register bit positions
  localparam int FCNT_CTRL_EN0 = 0;
  localparam int FCNT_CTRL_SET0 = 1;
  localparam int FCNT_CTRL_UD0 = 2;
  localparam int FCNT_CTRL_EN1 = 4;
  localparam int FCNT_CTRL_SET1 = 5;
  localparam int FCNT_CTRL_UD1 = 6;

  // fault codes
  localparam logic [7:0] FCNT_FAULT_NONE  = 8'h00;
  localparam logic [7:0] FCNT_FAULT_MODE  = 8'h01; // unknown mode latched
  localparam logic [7:0] FCNT_FAULT_HIGH  = 8'h02; // high byte of mode word not zero

  localparam logic [15:0] FCNT_MODE_RESET = 16'h0000;
  localparam logic [15:0] FCNT_ZERO16     = 16'h0000;

  // 50 kHz maximum count rate against the 40 MHz clock
  localparam int FCNT_CLK_HZ      = 40000000;
  localparam int FCNT_MAX_RATE_HZ = 50000;
  localparam int FCNT_MIN_PERIOD_CYC = FCNT_CLK_HZ / FCNT_MAX_RATE_HZ;

  typedef enum logic [7:0] {
    FCNT_M_NONE = 8'h00,
    FCNT_M_UP   = 8'h01,
    FCNT_M_GATE = 8'h02,
    FCNT_M_DUAL = 8'h03,
    FCNT_M_DINV = 8'h04,
    FCNT_M_ESR  = 8'h05,
    FCNT_M_ESF  = 8'h06,
    FCNT_M_QUAD = 8'h07
  } fcnt_mode_type;
endpackage

/* File: hw/fcnt_cnt_if.sv */
`timescale 1ns/1ps
// controls and results of one counter channel
interface fcnt_cnt_if;
  logic        step_up;
  logic        step_dn;
  logic        load;
  logic [15:0] preload;
  logic [15:0] target;
  logic [15:0] count;
  logic        reached;
  modport ctl (output step_up, step_dn, load, preload, target, input count, reached);
  modport cnt (input step_up, step_dn, load, preload, target, output count, reached);
endinterface

/* File: hw/fcnt_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser and edge detector for one fast pin
module fcnt_sync (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o  = sync_r & ~prev_r;
  assign fall_o  = ~sync_r & prev_r;
endmodule

/* File: hw/fcnt_chan.sv */
`timescale 1ns/1ps
// one 16-bit signed counter with preload, wrap and sticky target flag
module fcnt_chan (
  input  wire logic clk_i,
  input  wire logic reset_i,
  fcnt_cnt_if.cnt   c
);
  import fcnt_pkg::*;
  logic [15:0] count_r;
  logic        reached_r;
  wire  [15:0] count_nxt;
  wire         moved;

  // plain binary wrap gives 7fff->8000 and 8000->7fff for free
  assign count_nxt = c.load    ? c.preload :
                     c.step_up ? 16'(count_r + 16'h0001) :
                     c.step_dn ? 16'(count_r - 16'h0001) : count_r;
  assign moved = c.load | c.step_up | c.step_dn;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_r   <= FCNT_ZERO16;
      reached_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      // flag is sticky; only a load clears it, a step onto target sets it
      if (c.load)
        reached_r <= 1'b0;
      else if (moved && count_nxt == c.target)
        reached_r <= 1'b1;
    end
  end

  assign c.count   = count_r;
  assign c.reached = reached_r;
endmodule

/* File: tb/fcnt_src.sv */
`timescale 1ns/1ps
// pulse source and two-track position sensor in front of the fast pins
module fcnt_src
  import fcnt_pkg::*;
(
  input  wire logic clk_i,
  output logic      pin_a_o,
  output logic      pin_b_o
);
  import fcnt_pkg::*;
  localparam int HALF = FCNT_MIN_PERIOD_CYC / 2;

  initial begin
    pin_a_o = 1'b0;
    pin_b_o = 1'b0;
  end

  // one half period of the fastest legal pulse train
  task automatic hold();
    repeat (HALF) @(posedge clk_i);
  endtask

  // full pulses at the top rate, never faster, so no count may be lost
  task automatic pulses(input bit on_b, input int n);
    repeat (n) begin
      if (on_b) pin_b_o <= 1'b1; else pin_a_o <= 1'b1;
      hold();
      if (on_b) pin_b_o <= 1'b0; else pin_a_o <= 1'b0;
      hold();
    end
  endtask

  // level change on the second pin, held long enough to be seen
  task automatic set_b(input bit v);
    pin_b_o <= v;
    hold();
  endtask

  // whole signal cycles only, no index track; a leading b means down
  task automatic quad(input bit down, input int n);
    repeat (n) begin
      if (down) begin
        pin_b_o <= 1'b1; hold(); pin_a_o <= 1'b1; hold();
        pin_b_o <= 1'b0; hold(); pin_a_o <= 1'b0; hold();
      end else begin
        pin_a_o <= 1'b1; hold(); pin_b_o <= 1'b1; hold();
        pin_a_o <= 1'b0; hold(); pin_b_o <= 1'b0; hold();
      end
    end
  endtask
endmodule

/* File: tb/fcnt_top_chk.sv */
`timescale 1ns/1ps
// port-level checks of the fast counter
module fcnt_top_chk
  import fcnt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        count_input_pin_i,
  input  wire logic        second_input_pin_i,
  input  wire logic        program_cycle_end_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] rdata_o,
  input  wire logic        target_reached_pin_o,
  input  wire logic        pins_released_o,
  input  wire logic        fault_flag_o
);
  import fcnt_pkg::*;
  wire init_wr = wr_i && (addr_i == FCNT_ADDR_INIT);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_read_idle : assert property (
    !$past(rd_i) |-> rdata_o == 16'h0000) else $error("read data outside its slot");
  a_released_quiet : assert property (
    pins_released_o |-> !target_reached_pin_o) else $error("output pin driven in mode 0");
  a_fault_status : assert property (
    rd_i && addr_i == FCNT_ADDR_STATUS |=> rdata_o[2] == (rdata_o[15:8] != 8'h00))
    else $error("fault bit disagrees with fault code");
  a_fault_fallback : assert property (
    fault_flag_o |-> pins_released_o) else $error("bad mode word not dropped to mode 0");
  a_mode_at_init : assert property (
    $changed(pins_released_o) |-> $past(init_wr) || $past(init_wr, 2) || $past(init_wr, 3))
    else $error("mode changed without initialization");
  a_flag_sticky : assert property (
    (!wr_i && !program_cycle_end_i && $stable(second_input_pin_i))[*5] ##0
    target_reached_pin_o |=> target_reached_pin_o) else $error("target flag dropped");
  a_count_steady : assert property (
    (!wr_i && !program_cycle_end_i && $stable(count_input_pin_i)
     && $stable(second_input_pin_i))[*5] ##0 (rd_i && addr_i == FCNT_ADDR_COUNT0) ##2
    (rd_i && addr_i == FCNT_ADDR_COUNT0) |=> rdata_o == $past(rdata_o, 2))
    else $error("count moved without pulses");
  a_status_mode : assert property (
    rd_i && addr_i == FCNT_ADDR_STATUS && $stable(pins_released_o)
    |=> (rdata_o[7:4] == 4'h0) == pins_released_o) else $error("mode field disagrees");
endmodule

bind fcnt_top fcnt_top_chk u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .count_input_pin_i(count_input_pin_i),
  .second_input_pin_i(second_input_pin_i), .program_cycle_end_i(program_cycle_end_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .target_reached_pin_o(target_reached_pin_o), .pins_released_o(pins_released_o),
  .fault_flag_o(fault_flag_o)
);

/* File: tb/fast_updown_counter_tb.sv */
`timescale 1ns/1ps
module fast_updown_counter_tb;
  import fcnt_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_i;
  logic        pce;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic        rd_p = 1'b0;
  logic [15:0] rdata_o;
  logic        pin_a, pin_b, tpin, rel, fault;
  logic [15:0] v;
  logic [15:0] expq[$];
  int          errors = 0;
  int          checked = 0;

  always #12.5 clk_i = ~clk_i;

  fcnt_src u_src (.clk_i(clk_i), .pin_a_o(pin_a), .pin_b_o(pin_b));
  fcnt_top u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .count_input_pin_i(pin_a), .second_input_pin_i(pin_b),
    .program_cycle_end_i(pce), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .target_reached_pin_o(tpin), .pins_released_o(rel),
    .fault_flag_o(fault));

  task automatic test_done();
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // strobes drop for one cycle between accesses, so no signal is set twice at once
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge clk_i); wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    expq.push_back(e);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i); rd_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic start(input logic [15:0] m);
    wr(FCNT_ADDR_MODE, m);
    wr(FCNT_ADDR_INIT, 16'h0000);
    repeat (3) @(posedge clk_i);
  endtask

  // read data stands only in the cycle after the strobe; judged mid-cycle
  always @(posedge clk_i) rd_p <= rd_i;
  always @(negedge clk_i) begin
    if (rd_p) begin
      if (expq.size() == 0) chk(rdata_o, 16'hdead);
      else chk(rdata_o, expq.pop_front());
    end
  end

  // main sequence
  initial begin
    reset_i = 1'b1;
    pce = 1'b0;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    void'($urandom(97909));
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(FCNT_ADDR_MODE, FCNT_MODE_RESET);
    rd(FCNT_ADDR_STATUS, FCNT_ZERO16);
    rd(4'hf, FCNT_ZERO16);
    wr(FCNT_ADDR_MODE, 16'h0001);
    repeat (4) @(posedge clk_i);
    chk({15'h0, rel}, 16'h0001);
    u_src.pulses(0, 1);
    rd(FCNT_ADDR_COUNT0, 16'h0000);
    rd(FCNT_ADDR_COUNT0, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      start(i ? 16'h0009 : 16'h0100);
      rd(FCNT_ADDR_STATUS, i ? 16'h0104 : 16'h0204);
      chk({15'h0, fault}, 16'h0001);
    end
    // mode 1: wrap upward through the target
    start(16'h0001);
    wr(FCNT_ADDR_PRELOAD, 16'h7ffe);
    wr(FCNT_ADDR_TARGET, 16'h8000);
    wr(FCNT_ADDR_CTRL, 16'h0003);
    wr(FCNT_ADDR_CTRL, 16'h0001);
    u_src.pulses(0, 3);
    rd(FCNT_ADDR_COUNT0, 16'h8001);
    rd(FCNT_ADDR_STATUS, 16'h0011);
    chk({15'h0, tpin}, 16'h0001);
    wr(FCNT_ADDR_CTRL, 16'h0000);
    repeat (3) @(posedge clk_i);
    chk({15'h0, tpin}, 16'h0000);
    u_src.pulses(0, 1);
    rd(FCNT_ADDR_COUNT0, 16'h8001);
    rd(FCNT_ADDR_STATUS, 16'h0011);
    wr(FCNT_ADDR_CTRL, 16'h0003);
    rd(FCNT_ADDR_COUNT0, 16'h7ffe);
    rd(FCNT_ADDR_STATUS, 16'h0010);
    u_src.pulses(0, 1);
    rd(FCNT_ADDR_COUNT0, 16'h7fff);
    pce <= 1'b1;
    @(posedge clk_i); pce <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(FCNT_ADDR_COUNT0, 16'h7ffe);
    // mode 2: second pin gates counting
    u_src.set_b(0);
    start(16'h0002);
    wr(FCNT_ADDR_CTRL, 16'h0003);
    wr(FCNT_ADDR_CTRL, 16'h0001);
    u_src.pulses(0, 1);
    rd(FCNT_ADDR_COUNT0, 16'h7ffe);
    u_src.set_b(1);
    u_src.pulses(0, 1);
    rd(FCNT_ADDR_COUNT0, 16'h7fff);
    u_src.set_b(0);
    // modes 3 and 4: counter 0 wraps downward, counter 1 edge choice
    for (int m = 3; m <= 4; m++) begin
      start(16'(m));
      v = 16'($urandom());
      wr(FCNT_ADDR_PRE1, v);
      wr(FCNT_ADDR_TGT1, v - 16'h0001);
      wr(FCNT_ADDR_PRELOAD, 16'h8001);
      wr(FCNT_ADDR_TARGET, 16'h7fff);
      wr(FCNT_ADDR_CTRL, 16'h0037);
      wr(FCNT_ADDR_CTRL, 16'h0015);
      u_src.set_b(1);
      rd(FCNT_ADDR_COUNT1, v + ((m == 3) ? 16'h0001 : 16'h0000));
      u_src.set_b(0);
      rd(FCNT_ADDR_COUNT1, v + 16'h0001);
      u_src.pulses(0, 2);
      rd(FCNT_ADDR_COUNT0, 16'h7fff);
      rd(FCNT_ADDR_STATUS, 16'(m * 16) | 16'h0001);
    end
    // modes 5 and 6: preload on one edge of the second pin only
    for (int m = 5; m <= 6; m++) begin
      u_src.set_b(m == 6);
      start(16'(m));
      wr(FCNT_ADDR_PRELOAD, 16'h1234);
      wr(FCNT_ADDR_CTRL, 16'h0001);
      u_src.pulses(0, 2);
      u_src.set_b(m == 5);
      rd(FCNT_ADDR_COUNT0, 16'h1234);
      u_src.pulses(0, 1);
      u_src.set_b(m == 6);
      rd(FCNT_ADDR_COUNT0, 16'h1235);
    end
    // mode 7: quadrature up, down onto the target, then a direction change
    u_src.set_b(0);
    start(16'h0007);
    wr(FCNT_ADDR_PRELOAD, 16'h0010);
    wr(FCNT_ADDR_TARGET, 16'h000e);
    wr(FCNT_ADDR_CTRL, 16'h0003);
    wr(FCNT_ADDR_CTRL, 16'h0001);
    u_src.quad(0, 3);
    rd(FCNT_ADDR_COUNT0, 16'h0013);
    u_src.quad(1, 5);
    rd(FCNT_ADDR_COUNT0, 16'h000e);
    rd(FCNT_ADDR_STATUS, 16'h0071);
    wr(FCNT_ADDR_CTRL, 16'h0005);
    rd(FCNT_ADDR_COUNT0, 16'h0010);
    repeat (3) @(posedge clk_i);
    test_done();
  end

  // hang guard, well above the expected run length
  initial begin
    repeat (90000) @(posedge clk_i);
    errors++;
    test_done();
  end
endmodule
